// *** tb.sv ***
// Self-checking bench for the work bit logic engine
module tb import wbl_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SEC = 20;
   localparam logic [34:0] PAT = 35'h5_a5c3_96e1;
   logic        clk, nrst, tick, tick_en, dot;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        heat, cool, ierr, burnout, shorted;
   logic [7:0]  awaddr, araddr, wb;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, alarm;
   logic [1:0]  bresp, rresp;
   logic [11:0] state;
   logic [2:0]  prog;
   logic [4:0]  seg;
   logic [5:0]  ev;
   logic [34:0] st;
   int          fail_count, checked;

   wbl_engine #(.SEC_CYCLES(SEC)) dut_u (
      .CLK_IN(clk), .NRST_IN(nrst),
      .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
      .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
      .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
      .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
      .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
      .RVALID_OUT(rvalid), .RREADY_IN(rready), .CYCLE_TICK_IN(tick),
      .ALARM_IN(alarm), .CTRL_HEAT_IN(heat), .CTRL_COOL_IN(cool),
      .INPUT_ERR_IN(ierr), .HEATER_BURNOUT_ALARM_IN(burnout),
      .HEATER_SHORT_ALARM_IN(shorted), .STATE_IN(state),
      .PROG_NUM_IN(prog), .SEGMENT_IN(seg), .EVENT_IN(ev),
      .WORK_BIT_OUT(wb), .DISPLAY_DOT_OUT(dot));

   wbl_status_model #(.TICK_PERIOD(4)) partner_u (
      .clk_in(clk), .nrst_in(nrst), .tick_en_in(tick_en), .status_in(st),
      .tick_out(tick), .event_out(ev), .alarm_out(alarm), .heat_out(heat),
      .cool_out(cool), .input_err_out(ierr), .burnout_out(burnout),
      .shorted_out(shorted), .state_out(state), .prog_num_out(prog),
      .segment_out(seg));

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic end_of_test();
      if (fail_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic timeout();
      chk("wait_bound", 32'h0, 32'h1);
      end_of_test();
   endtask : timeout

   // Write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int g = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (++g > 100) timeout();
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int g = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (++g > 100) timeout();
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic wait_ticks(input int n);
      int g = 0;
      while (n > 0) begin
         @(posedge clk);
         if (tick === 1'b1) n--;
         if (++g > 1000) timeout();
      end
   endtask : wait_ticks

   // Three ticks cover the event synchroniser before sampling
   task automatic settle();
      wait_ticks(3);
      repeat (2) @(posedge clk);
   endtask : settle

   task automatic wait_out(input logic v, output int n);
      n = 0;
      do begin
         @(posedge clk);
         if (++n > 5000) timeout();
      end while (wb[0] !== v);
   endtask : wait_out

   function automatic logic [31:0] sel4(input logic [5:0] a, b, c, d);
      return {2'h0, d, 2'h0, c, 2'h0, b, 2'h0, a};
   endfunction : sel4

   task automatic set_bit(input int n, input logic [7:0] cfg, input logic [31:0] sel, input logic [31:0] dly);
      logic [7:0] base;
      logic [1:0] r;
      base = 8'h40 + 8'(n * 16);
      axi_wr(base, {24'h0, cfg}, r);
      chk("cfg_resp", 32'(RESP_OK), 32'(r));
      axi_wr(base + 8'h04, sel, r);
      axi_wr(base + 8'h08, dly, r);
   endtask : set_bit

   function automatic logic f_op(input logic [2:0] op, input logic [3:0] v);
      case (op)
         OP_AND_OR: return (v[0] & v[1]) | (v[2] & v[3]);
         OP_OR_AND: return (v[0] | v[2]) & (v[1] | v[3]);
         OP_ANY:    return |v;
         OP_ALL:    return &v;
         default:   return 1'b0;
      endcase
   endfunction : f_op

   // Status vector layout mirrors the source codes, gap at 33
   function automatic logic f_src(input int c, input logic [34:0] s, input logic [7:0] w);
      if (c >= 3 && c <= 32) return s[c-3];
      if (c >= 34 && c <= 38) return s[c-4];
      if (c >= 39 && c <= 46) return w[c-39];
      return c == 1;
   endfunction : f_src

   task automatic t_reset();
      logic [7:0]  adr [5] = '{8'h00, 8'h04, 8'h70, 8'h74, 8'h78};
      logic [31:0] d;
      logic [1:0]  r;
      foreach (adr[i]) begin
         axi_rd(adr[i], d, r);
         chk("reset_value", 32'h0, d);
      end
      chk("reset_outputs", 32'h0, {23'h0, dot, wb});
      axi_rd(8'h7c, d, r);
      chk("bad_rd_resp", 32'(RESP_ERR), 32'(r));
      chk("bad_rd_data", 32'h0, d);
      axi_wr(8'h0c, 32'hffff_ffff, r);
      chk("bad_wr_resp", 32'(RESP_ERR), 32'(r));
   endtask : t_reset

   // Ticks held back until the power-up source is selected
   task automatic t_powerup();
      set_bit(0, {5'h0, OP_ANY}, sel4(6'h02, 6'h00, 6'h00, 6'h00), 32'h0);
      tick_en <= 1'b1;
      wait_ticks(1);
      repeat (2) @(posedge clk);
      chk("powerup_first", 32'h1, 32'(wb[0]));
      chk("dot_on", 32'h1, 32'(dot));
      wait_ticks(1);
      repeat (2) @(posedge clk);
      chk("powerup_later", 32'h0, 32'(wb[0]));
   endtask : t_powerup

   task automatic t_ops();
      logic [1:0] r;
      set_bit(0, 8'h00, sel4(6'h09, 6'h0a, 6'h0b, 6'h0c), 32'h0);
      for (int op = 0; op < 5; op++) begin
         axi_wr(8'h40, 32'(op), r);
         for (int v = 0; v < 16; v++) begin
            st[9:6] <= 4'(v);
            settle();
            chk("op_result", 32'(f_op(3'(op), 4'(v))), 32'(wb[0]));
         end
      end
   endtask : t_ops

   // Each code lands in slot code mod 4; work bit 8 held on as feedback
   task automatic t_codes();
      logic [1:0]  r;
      logic        e;
      logic        prev;
      logic [34:0] s;
      prev = 1'b0;
      set_bit(7, {5'h0, OP_ANY}, sel4(6'h01, 6'h00, 6'h00, 6'h00), 32'h0);
      axi_wr(8'h40, {29'h0, OP_ANY}, r);
      for (int c = 0; c < 48; c++) begin
         axi_wr(8'h44, 32'(c) << (8 * (c % 4)), r);
         for (int p = 0; p < 2; p++) begin
            s = p ? ~PAT : PAT;
            st <= s;
            settle();
            e = f_src(c, s, {1'b1, 6'h00, prev});
            chk("source_code", 32'(e), 32'(wb[0]));
            prev = e;
         end
      end
   endtask : t_codes

   task automatic t_inv();
      logic [1:0] r;
      axi_wr(8'h44, 32'h0101_0101, r);
      for (int k = 0; k < 32; k++) begin
         axi_wr(8'h40, {24'h0, k[4], k[3:0], OP_ALL}, r);
         settle();
         chk("inversion", 32'((k[3:0] == 4'h0) ^ k[4]), 32'(wb[0]));
      end
   endtask : t_inv

   // Work bit 2 follows work bit 1 one tick later
   task automatic t_chain();
      logic [31:0] d;
      logic [1:0]  r;
      set_bit(0, {5'h0, OP_ANY}, sel4(6'h09, 6'h00, 6'h00, 6'h00), 32'h0);
      set_bit(1, {5'h0, OP_ANY}, sel4(6'h27, 6'h00, 6'h00, 6'h00), 32'h0);
      st <= '0;
      settle();
      wait_ticks(1);
      st[6] <= 1'b1;
      wait_ticks(1);
      repeat (2) @(posedge clk);
      chk("chain_first", 32'h1, 32'(wb[1:0]));
      wait_ticks(1);
      repeat (2) @(posedge clk);
      chk("chain_second", 32'h3, 32'(wb[1:0]));
      axi_rd(8'h04, d, r);
      chk("status_reg", 32'h0000_0183, d);
      chk("status_resp", 32'(RESP_OK), 32'(r));
   endtask : t_chain

   // Unit phase is free, so each delay is judged within one unit
   task automatic t_delay();
      int         n;
      logic       seen;
      logic [1:0] r;
      set_bit(0, {5'h0, OP_ANY}, sel4(6'h09, 6'h00, 6'h00, 6'h00), 32'h0002_0003);
      st[6] <= 1'b0;
      wait_out(1'b0, n);
      st[6] <= 1'b1;
      repeat (30) @(posedge clk);
      st[6] <= 1'b0;
      seen = 1'b0;
      repeat (150) begin
         @(posedge clk);
         seen = seen | (wb[0] !== 1'b0);
      end
      chk("short_pulse", 32'h0, 32'(seen));
      st[6] <= 1'b1;
      wait_out(1'b1, n);
      chk("on_delay", 32'h1, 32'(n >= 2*SEC && n <= 3*SEC+10));
      st[6] <= 1'b0;
      wait_out(1'b0, n);
      chk("off_delay", 32'h1, 32'(n >= SEC && n <= 2*SEC+10));
      axi_wr(8'h00, 32'h1, r);
      axi_wr(8'h48, 32'h0000_0002, r);
      st[6] <= 1'b1;
      wait_out(1'b1, n);
      chk("minute_delay", 32'h1, 32'(n >= 60*SEC && n <= 120*SEC+10));
   endtask : t_delay

   task automatic t_clear();
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(8'h00, 32'h2, r);
      axi_rd(8'h40, d, r);
      chk("clear_cfg", 32'h0, d);
      chk("clear_outputs", 32'h0, {23'h0, dot, wb});
   endtask : t_clear

   // Main sequence
   initial begin
      nrst = 1'b0;
      tick_en = 1'b0;
      st = '0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wstrb} = 20'h00000;
      wdata = 32'h0;
      fail_count = 0;
      checked = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_powerup();
      t_ops();
      t_codes();
      t_inv();
      t_chain();
      t_delay();
      t_clear();
      end_of_test();
   end
endmodule : tb

// *** wbl_engine.sv ***
// Work bit logic engine with AXI4-Lite configuration
module wbl_engine
   import wbl_pkg::*;
#(
   parameter int SEC_CYCLES = SEC_CYCLES_DEF
)(
   // Clock and reset
   input  wire logic                CLK_IN,
   input  wire logic                NRST_IN,
   // AXI4-Lite write channels
   input  wire logic [7:0]          AWADDR_IN,
   input  wire logic                AWVALID_IN,
   output logic                     AWREADY_OUT,
   input  wire logic [31:0]         WDATA_IN,
   input  wire logic [3:0]          WSTRB_IN,
   input  wire logic                WVALID_IN,
   output logic                     WREADY_OUT,
   output logic [1:0]               BRESP_OUT,
   output logic                     BVALID_OUT,
   input  wire logic                BREADY_IN,
   // AXI4-Lite read channels
   input  wire logic [7:0]          ARADDR_IN,
   input  wire logic                ARVALID_IN,
   output logic                     ARREADY_OUT,
   output logic [31:0]              RDATA_OUT,
   output logic [1:0]               RRESP_OUT,
   output logic                     RVALID_OUT,
   input  wire logic                RREADY_IN,
   // Controller status, same clock
   input  wire logic                CYCLE_TICK_IN,
   input  wire logic [3:0]          ALARM_IN,
   input  wire logic                CTRL_HEAT_IN,
   input  wire logic                CTRL_COOL_IN,
   input  wire logic                INPUT_ERR_IN,
   input  wire logic                HEATER_BURNOUT_ALARM_IN,
   input  wire logic                HEATER_SHORT_ALARM_IN,
   input  wire logic [11:0]         STATE_IN,
   input  wire logic [2:0]          PROG_NUM_IN,
   input  wire logic [4:0]          SEGMENT_IN,
   // Event input pins, asynchronous
   input  wire logic [NUM_EV-1:0]   EVENT_IN,
   // Results
   output logic [NUM_BITS-1:0]      WORK_BIT_OUT,
   output logic                     DISPLAY_DOT_OUT
);
   localparam int SW = $clog2(SEC_CYCLES);

   // Word address decode shared by reads and writes
   function automatic logic [2:0] reg_kind(input logic [7:0] a);
      logic [2:0] k;
      k = K_BAD;
      if (a[7:2] == CTRL_OFS[7:2]) begin
         k = K_CTRL;
      end else if (a[7:2] == STAT_OFS[7:2]) begin
         k = K_STAT;
      end else if (a[7:4] >= WB_FIRST && a[7:4] <= WB_LAST) begin
         if (a[3:2] == CFG_WORD) k = K_CFG;
         else if (a[3:2] == SEL_WORD) k = K_SEL;
         else if (a[3:2] == DLY_WORD) k = K_DLY;
      end
      return k;
   endfunction : reg_kind

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
      end
      return r;
   endfunction : merge

   // One source bit out of the coded list
   function automatic logic pick(input logic [SEL_W-1:0] c,
      input logic [SRC_NUM-1:0] v);
      return (c < SEL_W'(SRC_NUM)) ? v[c] : 1'b0;
   endfunction : pick

   // The four AND/OR forms
   function automatic logic combine(input logic [2:0] op,
      input logic [3:0] x);
      logic r;
      r = 1'b0;
      case (op)
         OP_AND_OR: r = (x[0] & x[1]) | (x[2] & x[3]);
         OP_OR_AND: r = (x[0] | x[2]) & (x[1] | x[3]);
         OP_ANY:    r = |x;
         OP_ALL:    r = &x;
         default:   r = 1'b0;
      endcase
      return r;
   endfunction : combine

   logic                  aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0]            awaddr_q;
   logic [31:0]           wdata_q, rdata_q;
   logic [3:0]            wstrb_q;
   logic [1:0]            bresp_q, rresp_q;
   logic                  do_wr, cfg_clr, min_q;
   logic [2:0]            wkind;
   logic [2:0]            widx;
   logic [7:0]            cfg_q [NUM_BITS];
   logic [31:0]           sel_q [NUM_BITS];
   logic [31:0]           dly_q [NUM_BITS];
   logic [NUM_EV-1:0]     ev_s1, ev_s2, ev_s3, ev_q;
   logic [SW-1:0]         sec_cnt_q;
   logic [5:0]            min_cnt_q;
   logic                  sec_pulse, unit_pulse;
   logic                  first_q, dot_q;
   logic [SRC_NUM-1:0]    src;
   logic [NUM_BITS-1:0]   res, r_q, y_q;
   logic [DLY_W-1:0]      cnt_q [NUM_BITS];
   logic [DLY_W-1:0]      tgt [NUM_BITS];

   // Write side: address and data taken in either order
   assign AWREADY_OUT = !aw_q && !bvalid_q;
   assign WREADY_OUT  = !w_q && !bvalid_q;
   assign do_wr       = aw_q && w_q && !bvalid_q;
   assign wkind       = reg_kind(awaddr_q);
   assign widx        = 3'(awaddr_q[7:4] - WB_FIRST);
   assign cfg_clr     = do_wr && wkind == K_CTRL && wstrb_q[0]
                        && wdata_q[CTRL_CLR_BIT];

   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else begin
         if (AWVALID_IN && AWREADY_OUT) begin
            aw_q     <= 1'b1;
            awaddr_q <= AWADDR_IN;
         end else if (do_wr) begin
            aw_q <= 1'b0;
         end
         if (WVALID_IN && WREADY_OUT) begin
            w_q     <= 1'b1;
            wdata_q <= WDATA_IN;
            wstrb_q <= WSTRB_IN;
         end else if (do_wr) begin
            w_q <= 1'b0;
         end
      end
   end

   // Write response, held until accepted
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OK;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wkind == K_BAD) ? RESP_ERR : RESP_OK;
      end else if (BREADY_IN) begin
         bvalid_q <= 1'b0;
      end
   end

   // Configuration store; clear loads the no-operation defaults
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN || cfg_clr) begin
         for (int i = 0; i < NUM_BITS; i++) begin
            cfg_q[i] <= CFG_RST;
            sel_q[i] <= SEL_RST;
            dly_q[i] <= DLY_RST;
         end
      end else if (do_wr) begin
         case (wkind)
            K_CFG: begin
               if (wstrb_q[0]) cfg_q[widx] <= wdata_q[7:0];
            end
            K_SEL: sel_q[widx] <= merge(sel_q[widx], wdata_q, wstrb_q);
            K_DLY: dly_q[widx] <= merge(dly_q[widx], wdata_q, wstrb_q);
            default: ;
         endcase
      end
   end

   // Delay unit select is not reset by a clear; the clearing write loads it from bit 0
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         min_q <= 1'b0;
      end else if (do_wr && wkind == K_CTRL && wstrb_q[0]) begin
         min_q <= wdata_q[CTRL_MIN_BIT];
      end
   end

   // Read side: one read at a time, data from flip-flops
   assign ARREADY_OUT = !rvalid_q;
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OK;
      end else if (ARVALID_IN && ARREADY_OUT) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OK;
         rdata_q  <= 32'h0000_0000;
         case (reg_kind(ARADDR_IN))
            K_CTRL: rdata_q[CTRL_MIN_BIT] <= min_q;
            K_STAT: rdata_q <= {23'h000000, dot_q, y_q};
            K_CFG:  rdata_q[7:0] <= cfg_q[3'(ARADDR_IN[7:4] - WB_FIRST)];
            K_SEL:  rdata_q <= sel_q[3'(ARADDR_IN[7:4] - WB_FIRST)];
            K_DLY:  rdata_q <= dly_q[3'(ARADDR_IN[7:4] - WB_FIRST)];
            default: rresp_q <= RESP_ERR;
         endcase
      end else if (RREADY_IN) begin
         rvalid_q <= 1'b0;
      end
   end

   assign BVALID_OUT = bvalid_q;
   assign BRESP_OUT  = bresp_q;
   assign RVALID_OUT = rvalid_q;
   assign RDATA_OUT  = rdata_q;
   assign RRESP_OUT  = rresp_q;

   // Event pins: a change counts once stages two and three agree
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         ev_s1 <= '0;
         ev_s2 <= '0;
         ev_s3 <= '0;
         ev_q  <= '0;
      end else begin
         ev_s1 <= EVENT_IN;
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
         ev_q  <= (ev_s2 & ev_s3) | (ev_q & (ev_s2 ^ ev_s3));
      end
   end

   // Second and minute enables for the delay counters
   assign sec_pulse  = sec_cnt_q == SW'(SEC_CYCLES - 1);
   assign unit_pulse = sec_pulse
                       && (!min_q || min_cnt_q == 6'(SEC_PER_MIN - 1));
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         sec_cnt_q <= '0;
         min_cnt_q <= 6'h00;
      end else if (sec_pulse) begin
         sec_cnt_q <= '0;
         min_cnt_q <= (min_cnt_q == 6'(SEC_PER_MIN - 1)) ? 6'h00
                      : min_cnt_q + 6'h01;
      end else begin
         sec_cnt_q <= sec_cnt_q + SW'(1);
      end
   end

   // Power-up flag stays true through the first evaluation only
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         first_q <= 1'b1;
      end else if (CYCLE_TICK_IN) begin
         first_q <= 1'b0;
      end
   end

   // Coded source list, code n at bit n; code 33 is tied low
   assign src = {y_q, SEGMENT_IN, 1'b0, PROG_NUM_IN,
                 STATE_IN,
                 HEATER_SHORT_ALARM_IN, HEATER_BURNOUT_ALARM_IN,
                 INPUT_ERR_IN, CTRL_COOL_IN, CTRL_HEAT_IN,
                 ALARM_IN,
                 ev_q, first_q, 1'b1, 1'b0};

   // Condition each input, combine, invert the result
   always_comb begin
      logic [3:0] x;
      x = 4'h0;
      for (int i = 0; i < NUM_BITS; i++) begin
         for (int k = 0; k < 4; k++) begin
            x[k] = pick(sel_q[i][k*SEL_STRIDE +: SEL_W], src)
                   ^ cfg_q[i][CFG_INV_LSB + k];
         end
         res[i] = (cfg_q[i][2:0] == OP_NONE) ? 1'b0
                  : combine(cfg_q[i][2:0], x)
                    ^ cfg_q[i][CFG_NC_BIT];
         tgt[i] = r_q[i] ? dly_q[i][DLY_W-1:0]
                  : dly_q[i][DLY_OFF_LSB +: DLY_W];
      end
   end

   // All bits sample together; feedback sees last cycle's outputs
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         r_q <= '0;
      end else if (CYCLE_TICK_IN) begin
         r_q <= res;
      end
   end

   // Delay counters; any change of the result starts over
   always_ff @(posedge CLK_IN) begin
      for (int i = 0; i < NUM_BITS; i++) begin
         if (!NRST_IN || cfg_clr) begin
            cnt_q[i] <= '0;
         end else if ((CYCLE_TICK_IN && res[i] != r_q[i])
                      || r_q[i] == y_q[i]) begin
            cnt_q[i] <= '0;
         end else if (unit_pulse && cnt_q[i] != DLY_MAX) begin
            cnt_q[i] <= cnt_q[i] + DLY_W'(1);
         end
      end
   end

   // Output follows the result once its delay has run out
   always_ff @(posedge CLK_IN) begin
      for (int i = 0; i < NUM_BITS; i++) begin
         if (!NRST_IN || cfg_clr || cfg_q[i][2:0] == OP_NONE) begin
            y_q[i] <= 1'b0;
         end else if (r_q[i] != y_q[i]
                      && (tgt[i] == '0 || cnt_q[i] >= tgt[i])) begin
            y_q[i] <= r_q[i];
         end
      end
   end

   // Display dot whenever any bit has an operation type
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         dot_q <= 1'b0;
      end else begin
         dot_q <= 1'b0;
         for (int i = 0; i < NUM_BITS; i++) begin
            if (cfg_q[i][2:0] != OP_NONE) dot_q <= 1'b1;
         end
      end
   end

   // Results go straight to output and status-switch logic
   assign WORK_BIT_OUT    = y_q;
   assign DISPLAY_DOT_OUT = dot_q;

   // Checks on work bit 0, and the dot check on work bit 1, stand for all eight
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!NRST_IN);

   none_off_a: assert property ((cfg_q[0][2:0] == OP_NONE) |=> !y_q[0])
      else $error("idle work bit output not off");
   dot_lit_a: assert property ((cfg_q[1][2:0] != OP_NONE) |=>
      DISPLAY_DOT_OUT)
      else $error("display dot missing");
   first_once_a: assert property (!first_q |=> !first_q)
      else $error("power-up flag rose again");
   ev_filter_a: assert property ((ev_s2[0] != ev_s3[0]) |=> $stable(ev_q[0]))
      else $error("event taken before stages agree");
   tick_hold_a: assert property (!CYCLE_TICK_IN |=> $stable(r_q))
      else $error("result moved without tick");
   restart_a: assert property ((CYCLE_TICK_IN && res[0] != r_q[0])
      |=> cnt_q[0] == '0)
      else $error("delay not restarted");
   on_delay_a: assert property ($rose(y_q[0]) |->
      $past(tgt[0] == '0 || cnt_q[0] >= tgt[0]))
      else $error("output on before delay");
   off_delay_a: assert property (($fell(y_q[0]) &&
      $past(cfg_q[0][2:0] != OP_NONE) && !$past(cfg_clr)) |->
      $past(tgt[0] == '0 || cnt_q[0] >= tgt[0]))
      else $error("output off before delay");
   bresp_hold_a: assert property ((BVALID_OUT && !BREADY_IN) |=>
      BVALID_OUT && $stable(BRESP_OUT))
      else $error("write response dropped");

   rise_delayed_c: cover property (cnt_q[0] != '0 ##[1:50] $rose(y_q[0]));
   feedback_c: cover property (sel_q[1][SEL_W-1:0] == 6'h27 && y_q[1]);
   write_c: cover property (BVALID_OUT && BREADY_IN);
   read_c: cover property (RVALID_OUT && RREADY_IN);
endmodule : wbl_engine

// *** wbl_pkg.sv ***
// Shared constants for the work bit logic engine
package wbl_pkg;
   localparam int NUM_BITS = 8;
   localparam int NUM_EV   = 6;
   localparam int SEL_W    = 6;
   localparam int DLY_W    = 14;
   localparam int SRC_NUM  = 47;
   localparam logic [DLY_W-1:0] DLY_MAX = 14'h270f;
   // Operation types
   localparam logic [2:0] OP_NONE   = 3'h0;
   localparam logic [2:0] OP_AND_OR = 3'h1;
   localparam logic [2:0] OP_OR_AND = 3'h2;
   localparam logic [2:0] OP_ANY    = 3'h3;
   localparam logic [2:0] OP_ALL    = 3'h4;
   // Register byte offsets; work bit n at WB_BASE + n*16
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [3:0] WB_FIRST = 4'h4;
   localparam logic [3:0] WB_LAST  = 4'hb;
   localparam logic [1:0] CFG_WORD = 2'h0;
   localparam logic [1:0] SEL_WORD = 2'h1;
   localparam logic [1:0] DLY_WORD = 2'h2;
   // Field positions
   localparam int CTRL_MIN_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam int STAT_DOT_BIT = 8;
   localparam int CFG_INV_LSB  = 3;
   localparam int CFG_NC_BIT   = 7;
   localparam int SEL_STRIDE   = 8;
   localparam int DLY_OFF_LSB  = 16;
   // Reset values
   localparam logic [7:0]  CFG_RST = 8'h00;
   localparam logic [31:0] SEL_RST = 32'h0000_0000;
   localparam logic [31:0] DLY_RST = 32'h0000_0000;
   // Register kinds from address decode, and bus response codes
   localparam logic [2:0] K_CTRL = 3'h0;
   localparam logic [2:0] K_STAT = 3'h1;
   localparam logic [2:0] K_CFG  = 3'h2;
   localparam logic [2:0] K_SEL  = 3'h3;
   localparam logic [2:0] K_DLY  = 3'h4;
   localparam logic [2:0] K_BAD  = 3'h7;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // Timing: delay unit of one second at 10 ns clock
   localparam int CLK_PERIOD_NS  = 10;
   localparam int UNIT_S         = 1;
   localparam int SEC_CYCLES_DEF = UNIT_S * 1000000000 / CLK_PERIOD_NS;
   localparam int SEC_PER_MIN    = 60;
endpackage : wbl_pkg

// *** wbl_status_model.sv ***
// Behavioural model of the controller status side and its cycle tick
module wbl_status_model #(
   parameter int TICK_PERIOD = 4
)(
   // Clock, reset and tick enable
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        tick_en_in,
   // Status vector requested by the bench
   input  wire logic [34:0] status_in,
   // Controller status towards the engine
   output logic             tick_out,
   output logic [5:0]       event_out,
   output logic [3:0]       alarm_out,
   output logic             heat_out,
   output logic             cool_out,
   output logic             input_err_out,
   output logic             burnout_out,
   output logic             shorted_out,
   output logic [11:0]      state_out,
   output logic [2:0]       prog_num_out,
   output logic [4:0]       segment_out
);
   logic [7:0] cnt_q;
   logic       last_w;

   assign last_w = (cnt_q == 8'(TICK_PERIOD - 1));

   // Tick stands still while disabled, so the bench owns the first tick
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !tick_en_in) begin
         cnt_q    <= 8'h00;
         tick_out <= 1'b0;
      end else begin
         tick_out <= last_w;
         cnt_q    <= last_w ? 8'h00 : cnt_q + 8'h01;
      end
   end

   // Status levels follow the request one clock late, like a status scan
   always_ff @(posedge clk_in) begin
      {segment_out, prog_num_out, state_out, shorted_out, burnout_out,
       input_err_out, cool_out, heat_out, alarm_out, event_out} <= status_in;
   end
endmodule : wbl_status_model
